// ==== verilog/cpu_seq_pkg.sv ====
package cpu_seq_pkg;
  // widths of the sequencer
  localparam int          PC_W        = 12;             // program counter width
  localparam int          DATA_W      = 8;              // alu and accumulator width
  localparam int          INSTR_W     = 16;             // program word width
  localparam int          STACK_DEPTH = 6;              // return-address levels
  localparam int          AXI_AW      = 8;              // register byte address width
  // fixed addresses
  localparam logic [11:0] RESET_VECTOR = 12'h000;       // program start after reset
  localparam logic [11:0] IRQ_VECTOR   = 12'h004;       // interrupt entry address
  localparam logic [11:0] PC_STEP      = 12'h001;       // sequential advance
  // stack pointer marks
  localparam logic [2:0]  SP_EMPTY = 3'h0;              // nothing saved
  localparam logic [2:0]  SP_FULL  = 3'h6;              // all six levels in use
  localparam logic [2:0]  SP_STEP  = 3'h1;              // one level
  localparam logic [2:0]  SP_TOP   = 3'h5;              // index of the newest slot when full
  // register byte offsets
  localparam logic [7:0]  OFS_PCL  = 8'h00;             // pc_low_byte, write jumps in page
  localparam logic [7:0]  OFS_CTRL = 8'h04;             // run and interrupt enable
  localparam logic [7:0]  OFS_STAT = 8'h08;             // flags, stack full bit, phase
  localparam logic [7:0]  OFS_ACC  = 8'h0C;             // accumulator
  localparam logic [7:0]  OFS_PC   = 8'h10;             // full program counter
  localparam logic [7:0]  OFS_WORK = 8'h14;             // working register
  // control and status field positions
  localparam int          CTRL_RUN   = 0;               // sequencer advances when set
  localparam int          CTRL_INTEN = 1;               // interrupts accepted when set
  localparam logic        RUN_RESET   = 1'b1;           // run from reset
  localparam int          STAT_FLAG_LSB = 0;            // four flags c, ac, z, ov
  localparam int          STAT_FULL     = 4;            // stack full
  localparam int          STAT_SP_LSB   = 8;            // stack pointer field, not filled by reads, reads zero
  localparam int          STAT_PH_LSB   = 12;           // current phase
  // bus answers
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;           // write to a read-only register
  localparam logic [1:0]  RESP_DECERR = 2'h3;           // unmapped address
  // instruction word fields
  localparam int          OP_MSB = 15;
  localparam int          OP_LSB = 13;
  localparam int          FN_MSB = 12;
  localparam int          FN_LSB = 9;
  localparam int          SK_MSB = 12;
  localparam int          SK_LSB = 11;
  localparam int          DST_BIT  = 8;                 // 1: register destination form
  localparam int          INTERRUPT_RETURN_BIT = 0;                 // return also re-enables interrupts
  // decimal adjust constants
  localparam logic [3:0]  BCD_MAX    = 4'h9;
  localparam logic [8:0]  BCD_ADJ_LO = 9'h006;
  localparam logic [8:0]  BCD_ADJ_HI = 9'h060;

  // four phases of one instruction cycle
  typedef enum logic [1:0] {PH_FETCH, PH_DECODE, PH_EXECUTE, PH_COMMIT} phase_e;
  // instruction classes
  typedef enum logic [2:0] {OP_NOP, OP_ALU, OP_JUMP, OP_CALL, OP_RETURN, OP_SKIP,
                            OP_PCLWR, OP_MOVE} opcode_e;
  // alu functions
  typedef enum logic [3:0] {ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_DAA, ALU_AND, ALU_OR,
                            ALU_XOR, ALU_CPL, ALU_RR, ALU_RRC, ALU_RL, ALU_RLC, ALU_INC,
                            ALU_DEC, ALU_PASS} alu_e;
  // conditional skip kinds
  typedef enum logic [1:0] {SKIP_ZERO, SKIP_NONZERO, SKIP_INC_ZERO, SKIP_DEC_ZERO} skip_e;

  // status flags
  typedef struct packed {
    logic ov;
    logic z;
    logic ac;
    logic c;
  } flags_s;
  // alu result with flags
  typedef struct packed {
    logic [7:0] res;
    flags_s     flags;
  } alu_out_s;
  // axi4-lite master to slave
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axi_req_s;
  // axi4-lite slave to master
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_s;
endpackage : cpu_seq_pkg

// ==== verilog/cpu_program_sequencer.sv ====
`timescale 1ns/10ps
// Summary of operation
// - four phases form one instruction cycle
// - first phase advances counter and starts fetch
// - later phases decode and execute previous word
// - fetch overlaps execute; one cycle per word
// - counter-changing instructions take one extra cycle
// - met skip discards fetched word, dummy cycle
// - sequential instructions advance counter by one
// - jump, call, interrupt, reset load target
// - twelve-bit counter, low byte and full value readable
// - low byte write jumps in page, dummy
// - six-level stack, hidden entries and pointer
// - call and interrupt acknowledge push counter
// - returns pop stack into counter
// - reset empties the stack
// - full stack withholds interrupt acknowledge
// - call on full stack drops oldest
// - eight-bit alu works through accumulator
// - alu operations update status flags
// - full alu set, both destination forms
// - reset starts execution at address zero
module cpu_program_sequencer
  import cpu_seq_pkg::*;
(
  // clock and reset
  input  wire  logic               ref_clk,
  input  wire  logic               nrst,
  // register bus
  input  wire  axi_req_s           axiReq,
  output       axi_rsp_s           axiRsp,
  // program memory
  output       logic [PC_W-1:0]    progAddr,
  output       logic               progRd,
  input  wire  logic [INSTR_W-1:0] progData,
  // interrupt logic
  input  wire  logic               irqReq,
  output       logic               irqAck,
  // observation
  output       phase_e             instrPhase
);

  // complete state of the sequencer
  typedef struct packed {
    phase_e                         phase;       // current phase
    logic [PC_W-1:0]                pc;          // next fetch address
    logic [PC_W-1:0]                fetchAddr;   // address on the memory port
    logic                           fetchRd;     // fetch strobe
    logic                           fetchLive;   // a fetch is outstanding
    logic [INSTR_W-1:0]             instr;       // word under execution
    logic [PC_W-1:0]                instrAddr;   // its address
    logic                           instrValid;  // low for a dummy cycle
    logic [STACK_DEPTH-1:0][PC_W-1:0] stack;     // return addresses
    logic [2:0]                     sp;          // levels in use
    logic [DATA_W-1:0]              acc;         // accumulator
    logic [DATA_W-1:0]              work;        // working register
    flags_s                         flags;       // status flags
    logic                           run;         // sequencer enable
    logic                           intEn;       // interrupt enable
    logic                           ack;         // acknowledge pulse
    logic                           pclPend;     // bus write to low byte waiting
    logic [DATA_W-1:0]              pclVal;      // byte written
    logic                           awready;     // bus write address ready
    logic                           wready;      // bus write data ready
    logic                           awHeld;      // address captured
    logic                           wHeld;       // data captured
    logic [AXI_AW-1:0]              awAddr;      // captured address
    logic [31:0]                    wData;       // captured data
    logic [3:0]                     wStrb;       // captured strobes
    logic                           bvalid;      // write response valid
    logic [1:0]                     bresp;       // write response code
    logic                           arready;     // read address ready
    logic                           rvalid;      // read data valid
    logic [31:0]                    rdata;       // read data
    logic [1:0]                     rresp;       // read response code
  } seq_s;

  logic [1:0] rstSync;   // reset release chain
  logic       rstN;      // synchronised reset
  seq_s       s_reg;     // registered state
  seq_s       s_next;    // next state

  // alu: a is the accumulator, b the second operand, u the single operand
  function automatic alu_out_s alu_calc(input alu_e fn, input logic [7:0] a,
                                        input logic [7:0] b, input logic [7:0] u,
                                        input flags_s f);
    alu_out_s   o;
    logic [7:0] bb;
    logic       cin;
    logic [8:0] sum;
    logic [4:0] half;
    logic [8:0] adj;
    o = '{res: u, flags: f};
    bb = ((fn == ALU_SUB) || (fn == ALU_SBC)) ? ~b : b;
    cin = (fn == ALU_ADC) || (fn == ALU_SBC) ? f.c : (fn == ALU_SUB);
    sum = {1'b0, a} + {1'b0, bb} + {8'h00, cin};
    half = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
    adj = {1'b0, u};
    unique case (fn)
      // add and subtract share one adder; carry set means no borrow
      ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC: begin
        o.res = sum[7:0];
        o.flags.c = sum[8];
        o.flags.ac = half[4];
        o.flags.ov = (a[7] == bb[7]) && (sum[7] != a[7]);
      end
      // decimal adjust of the operand
      ALU_DAA: begin
        if ((u[3:0] > BCD_MAX) || f.ac) begin
          adj = adj + BCD_ADJ_LO;
        end
        if ((adj[7:4] > BCD_MAX) || f.c || adj[8]) begin
          adj = adj + BCD_ADJ_HI;
        end
        o.res = adj[7:0];
        o.flags.c = adj[8] | f.c;
      end
      ALU_AND:  o.res = a & b;
      ALU_OR:   o.res = a | b;
      ALU_XOR:  o.res = a ^ b;
      ALU_CPL:  o.res = ~u;
      ALU_RR:   o.res = {u[0], u[7:1]};
      // rotates through carry
      ALU_RRC: begin
        o.res = {f.c, u[7:1]};
        o.flags.c = u[0];
      end
      ALU_RL:   o.res = {u[6:0], u[7]};
      ALU_RLC: begin
        o.res = {u[6:0], f.c};
        o.flags.c = u[7];
      end
      ALU_INC:  o.res = u + 8'h01;
      ALU_DEC:  o.res = u - 8'h01;
      ALU_PASS: o.res = b;
    endcase
    // zero flag follows every result except the four rotates
    if (!((fn == ALU_RR) || (fn == ALU_RRC) || (fn == ALU_RL) || (fn == ALU_RLC))) begin
      o.flags.z = (o.res == 8'h00);
    end
    return o;
  endfunction : alu_calc

  // reset release through two flip-flops
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rstSync <= 2'b00;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstN = rstSync[1];

  // next-state logic
  always_comb begin
    opcode_e         op;
    alu_out_s        ao;
    logic            branch;
    logic            flush;
    logic            doPush;
    logic            doPop;
    logic [PC_W-1:0] target;
    logic [PC_W-1:0] pushVal;
    logic [PC_W-1:0] popVal;
    logic [PC_W-1:0] pcBase;
    logic [7:0]      skipVal;
    logic            wrEn;
    s_next = s_reg;
    op = opcode_e'(s_reg.instr[OP_MSB:OP_LSB]);
    ao = alu_calc(alu_e'(s_reg.instr[FN_MSB:FN_LSB]), s_reg.acc,
                  s_reg.instr[DST_BIT] ? s_reg.work : s_reg.instr[7:0],
                  s_reg.instr[DST_BIT] ? s_reg.work : s_reg.acc, s_reg.flags);
    branch = 1'b0;
    flush = 1'b0;
    doPush = 1'b0;
    doPop = 1'b0;
    target = s_reg.pc;
    pushVal = s_reg.instrAddr + PC_STEP;
    popVal = (s_reg.sp == SP_EMPTY) ? s_reg.stack[0] : s_reg.stack[s_reg.sp - SP_STEP];
    pcBase = s_reg.pc;
    skipVal = 8'h00;
    wrEn = 1'b0;
    s_next.fetchRd = 1'b0;
    s_next.ack = 1'b0;

    // phase sequencer: three phases pass, the fourth commits
    if (s_reg.run) begin
      unique case (s_reg.phase)
        PH_FETCH:   s_next.phase = PH_DECODE;
        PH_DECODE:  s_next.phase = PH_EXECUTE;
        PH_EXECUTE: s_next.phase = PH_COMMIT;
        PH_COMMIT: begin
          s_next.phase = PH_FETCH;
          if (s_reg.instrValid && irqReq && s_reg.intEn && (s_reg.sp != SP_FULL)) begin
            // interrupt entry replaces the word; its address is saved to rerun it
            pushVal = s_reg.instrAddr;
            doPush = 1'b1;
            branch = 1'b1;
            target = IRQ_VECTOR;
            s_next.intEn = 1'b0;
            s_next.ack = 1'b1;
          end else if (s_reg.instrValid) begin
            unique case (op)
              OP_NOP: ;
              // alu result goes to accumulator or working register
              OP_ALU: begin
                s_next.flags = ao.flags;
                if (s_reg.instr[DST_BIT]) begin
                  s_next.work = ao.res;
                end else begin
                  s_next.acc = ao.res;
                end
              end
              OP_JUMP: begin
                branch = 1'b1;
                target = s_reg.instr[PC_W-1:0];
              end
              OP_CALL: begin
                doPush = 1'b1;
                branch = 1'b1;
                target = s_reg.instr[PC_W-1:0];
              end
              OP_RETURN: begin
                doPop = 1'b1;
                branch = 1'b1;
                target = popVal;
                if (s_reg.instr[INTERRUPT_RETURN_BIT]) begin
                  s_next.intEn = 1'b1;
                end
              end
              // condition met: drop the prefetched word
              OP_SKIP: begin
                unique case (skip_e'(s_reg.instr[SK_MSB:SK_LSB]))
                  SKIP_ZERO:     flush = (s_reg.acc == 8'h00);
                  SKIP_NONZERO:  flush = (s_reg.acc != 8'h00);
                  SKIP_INC_ZERO: begin
                    skipVal = s_reg.work + 8'h01;
                    s_next.work = skipVal;
                    flush = (skipVal == 8'h00);
                  end
                  SKIP_DEC_ZERO: begin
                    skipVal = s_reg.work - 8'h01;
                    s_next.work = skipVal;
                    flush = (skipVal == 8'h00);
                  end
                endcase
              end
              // program writes the accumulator into the low byte
              OP_PCLWR: begin
                branch = 1'b1;
                target = {s_reg.pc[PC_W-1:DATA_W], s_reg.acc};
              end
              OP_MOVE: begin
                if (s_reg.instr[DST_BIT]) begin
                  s_next.work = s_reg.acc;
                end else begin
                  s_next.acc = s_reg.instr[7:0];
                end
              end
            endcase
          end
          // a bus write to the low byte jumps within the page when no other branch
          if (!branch && s_reg.pclPend) begin
            branch = 1'b1;
            target = {s_reg.pc[PC_W-1:DATA_W], s_reg.pclVal};
            s_next.pclPend = 1'b0;
          end
          flush = flush | branch;
          // load target or keep sequential address, then fetch and advance
          pcBase = branch ? target : s_reg.pc;
          s_next.fetchAddr = pcBase;
          s_next.pc = pcBase + PC_STEP;
          s_next.fetchRd = 1'b1;
          s_next.fetchLive = 1'b1;
          // word fetched this cycle becomes next to execute, unless discarded
          s_next.instr = progData;
          s_next.instrAddr = s_reg.fetchAddr;
          s_next.instrValid = s_reg.fetchLive && !flush;
        end
      endcase
    end

    // stack push; when full the oldest entry falls out
    if (doPush) begin
      if (s_reg.sp == SP_FULL) begin
        for (int i = 0; i < STACK_DEPTH - 1; i++) begin
          s_next.stack[i] = s_reg.stack[i + 1];
        end
        s_next.stack[SP_TOP] = pushVal;
      end else begin
        s_next.stack[s_reg.sp] = pushVal;
        s_next.sp = s_reg.sp + SP_STEP;
      end
    end else if (doPop && (s_reg.sp != SP_EMPTY)) begin
      s_next.sp = s_reg.sp - SP_STEP;
    end

    // bus: capture write address and data in either order
    if (s_reg.awready && axiReq.awvalid) begin
      s_next.awready = 1'b0;
      s_next.awHeld = 1'b1;
      s_next.awAddr = axiReq.awaddr;
    end
    if (s_reg.wready && axiReq.wvalid) begin
      s_next.wready = 1'b0;
      s_next.wHeld = 1'b1;
      s_next.wData = axiReq.wdata;
      s_next.wStrb = axiReq.wstrb;
    end
    // both held: perform the write and answer
    if (s_reg.awHeld && s_reg.wHeld && !s_reg.bvalid) begin
      s_next.awHeld = 1'b0;
      s_next.wHeld = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = RESP_OKAY;
      wrEn = s_reg.wStrb[0];
      unique case (s_reg.awAddr)
        OFS_PCL: begin
          if (wrEn) begin
            s_next.pclPend = 1'b1;
            s_next.pclVal = s_reg.wData[7:0];
          end
        end
        OFS_CTRL: begin
          if (wrEn) begin
            s_next.run = s_reg.wData[CTRL_RUN];
            s_next.intEn = s_reg.wData[CTRL_INTEN];
          end
        end
        OFS_STAT, OFS_ACC, OFS_PC, OFS_WORK: s_next.bresp = RESP_SLVERR;
        default: s_next.bresp = RESP_DECERR;
      endcase
    end
    // response taken: ready for the next write
    if (s_reg.bvalid && axiReq.bready) begin
      s_next.bvalid = 1'b0;
      s_next.awready = 1'b1;
      s_next.wready = 1'b1;
    end
    // bus read: low byte of the counter reads as pc_low_byte, the full counter at OFS_PC
    if (s_reg.arready && axiReq.arvalid) begin
      s_next.arready = 1'b0;
      s_next.rvalid = 1'b1;
      s_next.rdata = 32'h0000_0000;
      s_next.rresp = RESP_OKAY;
      unique case (axiReq.araddr)
        OFS_PCL:  s_next.rdata[DATA_W-1:0] = s_reg.pc[DATA_W-1:0];
        OFS_CTRL: begin
          s_next.rdata[CTRL_RUN] = s_reg.run;
          s_next.rdata[CTRL_INTEN] = s_reg.intEn;
        end
        OFS_STAT: begin
          s_next.rdata[STAT_FLAG_LSB +: 4] = s_reg.flags;
          s_next.rdata[STAT_FULL] = (s_reg.sp == SP_FULL);
          s_next.rdata[STAT_PH_LSB +: 2] = s_reg.phase;
        end
        OFS_ACC:  s_next.rdata[DATA_W-1:0] = s_reg.acc;
        OFS_PC:   s_next.rdata[PC_W-1:0] = s_reg.pc;
        OFS_WORK: s_next.rdata[DATA_W-1:0] = s_reg.work;
        default:  s_next.rresp = RESP_DECERR;
      endcase
    end
    // read data taken
    if (s_reg.rvalid && axiReq.rready) begin
      s_next.rvalid = 1'b0;
      s_next.arready = 1'b1;
    end
  end

  // state register
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      s_reg <= '0;
      s_reg.phase <= PH_COMMIT;       // first edge starts a fetch
      s_reg.pc <= RESET_VECTOR;
      s_reg.sp <= SP_EMPTY;
      s_reg.run <= RUN_RESET;
      s_reg.awready <= 1'b1;
      s_reg.wready <= 1'b1;
      s_reg.arready <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register
  assign progAddr = s_reg.fetchAddr;
  assign progRd = s_reg.fetchRd;
  assign irqAck = s_reg.ack;
  assign instrPhase = s_reg.phase;
  assign axiRsp = '{awready: s_reg.awready, wready: s_reg.wready, bvalid: s_reg.bvalid,
                    bresp: s_reg.bresp, arready: s_reg.arready, rvalid: s_reg.rvalid,
                    rdata: s_reg.rdata, rresp: s_reg.rresp};

endmodule : cpu_program_sequencer

// ==== verif/cpu_seq_properties.sv ====
`timescale 1ns/10ps
module cpu_seq_properties
  import cpu_seq_pkg::*;
(
  // clock and reset
  input wire logic            ref_clk,
  input wire logic            nrst,
  // bus and fetch side
  input wire axi_req_s        axiReq,
  input wire axi_rsp_s        axiRsp,
  input wire logic [PC_W-1:0] progAddr,
  input wire logic            progRd,
  // interrupt and phase
  input wire logic            irqReq,
  input wire logic            irqAck,
  input wire phase_e          instrPhase
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // phases only step forward by one
  a_phase_order: assert property ($changed(instrPhase) |->
    instrPhase == phase_e'($past(instrPhase) + 2'h1)) else $error("phase skipped");
  // one fetch pulse on entering the first phase
  a_fetch_pulse: assert property (
    progRd == (instrPhase == PH_FETCH && $changed(instrPhase))) else $error("bad fetch pulse");
  // fetch address stands between fetches
  a_addr_hold: assert property (!progRd |-> $stable(progAddr)) else $error("addr moved");
  // acknowledge goes with the vector fetch
  a_ack_vector: assert property (irqAck |-> progRd && progAddr == IRQ_VECTOR)
    else $error("ack without vector");
  // acknowledge only for a pending request
  a_ack_cause: assert property (irqAck |-> $past(irqReq)) else $error("ack no req");
  a_ack_pulse: assert property (irqAck |=> !irqAck) else $error("ack too long");
  // bus answers stand until taken
  a_resp_hold: assert property (axiRsp.bvalid && !axiReq.bready |=>
    axiRsp.bvalid && $stable(axiRsp.bresp)) else $error("bresp dropped");
  a_rdata_hold: assert property (axiRsp.rvalid && !axiReq.rready |=>
    axiRsp.rvalid && $stable(axiRsp.rdata)) else $error("rdata dropped");
  a_read_answer: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
    else $error("late read");
  // covers for the main scenarios
  c_ack: cover property (irqAck);
  c_write: cover property (axiRsp.bvalid && axiReq.bready);
  c_read: cover property (axiRsp.rvalid && axiReq.rready);
endmodule : cpu_seq_properties

// ==== verif/prog_mem_model.sv ====
`timescale 1ns/10ps
module prog_mem_model
  import cpu_seq_pkg::*;
(
  // fetch side
  input wire logic [PC_W-1:0]    progAddr,
  input wire logic               progRd,
  output     logic [INSTR_W-1:0] progData
);
  logic [INSTR_W-1:0] mem [0:4095]; // program words, filled by the bench
  // word is garbage while the address is just changing
  assign progData = progRd ? ~mem[progAddr] : mem[progAddr];
endmodule : prog_mem_model

// ==== verif/tb.sv ====
`timescale 1ns/10ps
module tb
  import cpu_seq_pkg::*;
;
  logic               ref_clk = 1'b0;
  logic               nrst = 1'b1;
  logic               irqReq = 1'b0;
  axi_req_s           axiReq = '0;
  axi_rsp_s           axiRsp;
  logic [PC_W-1:0]    progAddr;
  logic               progRd;
  logic [INSTR_W-1:0] progData;
  logic               irqAck;
  phase_e             instrPhase;
  int                 badCount = 0;
  int                 numChecks = 0;
  logic [PC_W-1:0]    fetches [$]; // fetch addresses seen
  always #50 ref_clk = ~ref_clk;
  // record each fetch
  always @(posedge ref_clk) if (progRd) fetches.push_back(progAddr);
  cpu_program_sequencer cpu_program_sequencer_i (.ref_clk, .nrst, .axiReq, .axiRsp,
    .progAddr, .progRd, .progData, .irqReq, .irqAck, .instrPhase);
  prog_mem_model prog_mem_model_i (.progAddr, .progRd, .progData);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    numChecks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      badCount++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge ref_clk);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr <= a;
    axiReq.wvalid <= 1'b1;
    axiReq.wdata <= d;
    axiReq.wstrb <= 4'hF;
    do begin
      @(posedge ref_clk);
      if (axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiRsp.wready) axiReq.wvalid <= 1'b0;
    end while (axiRsp.bvalid !== 1'b1);
    // ready only once the answer shows, so the answer must stand a cycle
    axiReq.bready <= 1'b1;
    @(posedge ref_clk);
    axiReq.bready <= 1'b0;
    chk("bresp", er, axiRsp.bresp);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m, input logic [1:0] er);
    @(posedge ref_clk);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr <= a;
    do begin
      @(posedge ref_clk);
      if (axiRsp.arready) axiReq.arvalid <= 1'b0;
    end while (axiRsp.rvalid !== 1'b1);
    // read data must stand until ready is sampled
    axiReq.rready <= 1'b1;
    @(posedge ref_clk);
    axiReq.rready <= 1'b0;
    chk("rresp", er, axiRsp.rresp);
    chk("rdata", e, axiRsp.rdata & m);
  endtask : rd
  // jump, call, return, skip and their dummy fetches
  task automatic test_fetch();
    logic [11:0] ex [14] = '{12'h000, 12'h001, 12'h002, 12'h003, 12'h010, 12'h011, 12'h020,
      12'h021, 12'h011, 12'h012, 12'h013, 12'h014, 12'h113, 12'h114};
    repeat (60) @(posedge ref_clk);
    foreach (ex[i]) chk("fetch", ex[i], fetches[i]);
  endtask : test_fetch
  // alu result, flags, refused accesses
  task automatic test_regs();
    rd(OFS_ACC, 32'h04, 32'hFF, RESP_OKAY);
    rd(OFS_STAT, 32'h03, 32'h1F, RESP_OKAY);
    rd(OFS_PC, 32'h100, 32'hF00, RESP_OKAY);
    wr(OFS_STAT, 32'h0, RESP_SLVERR);
    rd(8'h18, 32'h0, 32'h0, RESP_DECERR);
  endtask : test_regs
  // low byte write jumps within the current page
  task automatic test_pcl();
    logic hit = 1'b0;
    fetches.delete();
    wr(OFS_PCL, 32'h30, RESP_OKAY);
    repeat (24) @(posedge ref_clk);
    foreach (fetches[i]) if (fetches[i] === 12'h130) hit = 1'b1;
    chk("pcl jump", 32'h1, hit);
  endtask : test_pcl
  // interrupt entry
  task automatic test_irq();
    logic hit = 1'b0;
    wr(OFS_CTRL, 32'h3, RESP_OKAY);
    irqReq <= 1'b1;
    repeat (40) begin
      @(posedge ref_clk);
      if (irqAck === 1'b1 && !hit) begin
        hit = 1'b1;
        irqReq <= 1'b0;
        chk("vector", IRQ_VECTOR, progAddr);
      end
    end
    chk("irq ack", 32'h1, hit);
  endtask : test_irq
  // self-call fills and overflows the stack; a full stack holds the interrupt off
  task automatic test_stack();
    logic hit = 1'b0;
    wr(OFS_PCL, 32'h40, RESP_OKAY);
    repeat (80) @(posedge ref_clk);
    rd(OFS_STAT, 32'h10, 32'h10, RESP_OKAY);
    irqReq <= 1'b1;
    repeat (40) begin
      @(posedge ref_clk);
      if (irqAck === 1'b1) hit = 1'b1;
    end
    irqReq <= 1'b0;
    chk("held ack", 32'h0, hit);
  endtask : test_stack
  task automatic conclude();
    if (badCount == 0 && numChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  // main sequence
  initial begin
    // a real falling edge so the asynchronous reset takes hold
    nrst <= 1'b0;
    for (int i = 0; i < 4096; i++) prog_mem_model_i.mem[i] = 16'h0000;
    prog_mem_model_i.mem[12'h000] = 16'hE005;
    prog_mem_model_i.mem[12'h001] = 16'h20FF;
    prog_mem_model_i.mem[12'h002] = 16'h4010;
    prog_mem_model_i.mem[12'h004] = 16'h8001;
    prog_mem_model_i.mem[12'h010] = 16'h6020;
    prog_mem_model_i.mem[12'h011] = 16'hA800;
    prog_mem_model_i.mem[12'h012] = 16'h43FF;
    prog_mem_model_i.mem[12'h013] = 16'h4113;
    prog_mem_model_i.mem[12'h020] = 16'h8000;
    prog_mem_model_i.mem[12'h113] = 16'h4113;
    prog_mem_model_i.mem[12'h130] = 16'h4130;
    prog_mem_model_i.mem[12'h140] = 16'h6140;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    test_fetch();
    test_regs();
    test_pcl();
    test_irq();
    test_stack();
    conclude();
  end
  // watchdog
  initial begin
    #200000;
    badCount++;
    conclude();
  end
endmodule : tb
bind cpu_program_sequencer cpu_seq_properties cpu_seq_properties_i (.ref_clk, .nrst, .axiReq,
  .axiRsp, .progAddr, .progRd, .irqReq, .irqAck, .instrPhase);
